// ===== hdl/pattern_trigger_illumination_ctrl.sv
// pattern sequencer with trigger outputs and three-channel illumination pulses
// assumes host configuration arrives as plain level inputs, one clock domain
// Overview of operation
// - exposure output high during each pattern exposure, low otherwise
// - first-pattern output high while pattern zero is being exposed, low in idle and gap
// - advance trigger steps pattern; alternate mode toggles between two patterns
// - pause trigger pauses display; alternate mode advances by two patterns
// - trigger outputs let a camera sync acquisition to patterns
// - three independent illumination channels, each with own enable
// - each channel has a pulse output whose duty sets current
// - single emitter may use any one channel enable
// - global disable turns all enables off for external control
// - alive output toggles continuously while running without fault
// - fault output drives LED off on fault and during reset, lit otherwise
`timescale 1ns/1ps
module pattern_trigger_illumination_ctrl
  import pattern_trigger_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic advance_trigger_in,
  input wire logic pause_trigger_in,
  input wire logic alternate_mode_in,
  input wire logic [PAT_W-1:0] pattern_count_in,
  input wire logic [EXPO_W-1:0] exposure_cycles_in,
  input wire logic config_valid_in,
  input wire logic [2:0] channel_enable_in,
  input wire logic all_disable_in,
  input wire logic [DUTY_W-1:0] red_duty_in,
  input wire logic [DUTY_W-1:0] green_duty_in,
  input wire logic [DUTY_W-1:0] blue_duty_in,
  input wire logic system_fault_in,
  output logic exposure_trigger_out,
  output logic first_pattern_trigger_out,
  output logic [PAT_W-1:0] pattern_index_out,
  output logic paused_out,
  output logic red_light_enable,
  output logic green_light_enable,
  output logic blue_light_enable,
  output logic red_current_pulse,
  output logic green_current_pulse,
  output logic blue_current_pulse,
  output logic alive_blink_out,
  output logic fault_status_out
);
  typedef struct packed {
    seq_state_type seq;
    logic [PAT_W-1:0] pattern;
    logic [EXPO_W-1:0] expo_cnt;
    logic paused;
    logic configured;
    logic [2:0] enables;
    logic [DUTY_W-1:0] pwm_cnt;
    logic [2:0] pulses;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink;
    logic fault_led;
    logic expo_out;
    logic first_out;
  } ctrl_state_type;
  ctrl_state_type state_q, state_d;

  logic advance_rise;
  logic pause_rise;

  trigger_sync advance_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(advance_trigger_in),
    .rise_out(advance_rise)
  );
  trigger_sync pause_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(pause_trigger_in),
    .rise_out(pause_rise)
  );

  function automatic logic [PAT_W-1:0] step_pattern(input logic [PAT_W-1:0] cur,
                                                    input logic [PAT_W-1:0] delta,
                                                    input logic [PAT_W-1:0] count);
    logic [PAT_W:0] sum;
    sum = {1'b0, cur} + {1'b0, delta};
    // wrap keeps index inside the configured sequence
    if (count == '0) begin
      step_pattern = PAT_RESET;
    end else if (sum >= {1'b0, count}) begin
      step_pattern = PAT_W'(sum - {1'b0, count});
    end else begin
      step_pattern = sum[PAT_W-1:0];
    end
  endfunction

  always_comb begin
    state_d = state_q;
    if (state_q.seq == SEQ_IDLE || state_q.seq == SEQ_GAP) begin
      if (advance_rise) begin
        if (alternate_mode_in) begin
          state_d.pattern = (state_q.pattern == PAT_RESET) ? 8'h01 : PAT_RESET;
        end else if (state_q.seq == SEQ_GAP && !state_q.paused) begin
          // paused display holds its pattern
          state_d.pattern = step_pattern(state_q.pattern, 8'h01, pattern_count_in);
        end
        if (!state_q.paused || alternate_mode_in) begin
          state_d.seq = SEQ_EXPOSE;
          state_d.expo_cnt = exposure_cycles_in;
        end
      end else if (pause_rise) begin
        if (alternate_mode_in) begin
          state_d.pattern = step_pattern(state_q.pattern, 8'h02, pattern_count_in);
        end else begin
          state_d.paused = ~state_q.paused;
        end
      end
    end else begin
      if (state_q.expo_cnt <= 16'h0001) begin
        state_d.seq = SEQ_GAP;
        state_d.expo_cnt = '0;
      end else begin
        state_d.expo_cnt = state_q.expo_cnt - 16'h0001;
      end
    end
    state_d.expo_out = (state_d.seq == SEQ_EXPOSE);
    state_d.first_out = (state_d.seq == SEQ_EXPOSE) && (state_d.pattern == PAT_RESET);

    if (config_valid_in) begin
      state_d.configured = 1'b1;
    end
    state_d.enables = (state_q.configured && !all_disable_in) ? channel_enable_in : ENABLE_RESET;
    state_d.pwm_cnt = state_q.pwm_cnt + 8'h01;
    state_d.pulses[CH_RED] = state_q.enables[CH_RED] && (state_q.pwm_cnt < red_duty_in);
    state_d.pulses[CH_GREEN] = state_q.enables[CH_GREEN] && (state_q.pwm_cnt < green_duty_in);
    state_d.pulses[CH_BLUE] = state_q.enables[CH_BLUE] && (state_q.pwm_cnt < blue_duty_in);

    if (!system_fault_in) begin
      if (state_q.blink_cnt >= BLINK_W'(BLINK_HALF_CYCLES - 1)) begin
        state_d.blink_cnt = '0;
        state_d.blink = ~state_q.blink;
      end else begin
        state_d.blink_cnt = state_q.blink_cnt + 24'h000001;
      end
    end
    state_d.fault_led = ~system_fault_in;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= '0;
      state_q.seq <= SEQ_IDLE;
      state_q.pattern <= PAT_RESET;
      state_q.enables <= ENABLE_RESET;
      state_q.pwm_cnt <= DUTY_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign exposure_trigger_out = state_q.expo_out;
  assign first_pattern_trigger_out = state_q.first_out;
  assign pattern_index_out = state_q.pattern;
  assign paused_out = state_q.paused;
  assign red_light_enable = state_q.enables[CH_RED];
  assign green_light_enable = state_q.enables[CH_GREEN];
  assign blue_light_enable = state_q.enables[CH_BLUE];
  assign red_current_pulse = state_q.pulses[CH_RED];
  assign green_current_pulse = state_q.pulses[CH_GREEN];
  assign blue_current_pulse = state_q.pulses[CH_BLUE];
  assign alive_blink_out = state_q.blink;
  assign fault_status_out = state_q.fault_led;

  property p_expo_matches_state;
    @(posedge clock_in) disable iff (!rst_n_in)
      $rose(exposure_trigger_out) |-> state_q.expo_cnt == $past(exposure_cycles_in);
  endproperty
  a_expo_matches_state: assert property (p_expo_matches_state)
    else $error("exposure length not loaded at exposure start");

  property p_first_only_exposed;
    @(posedge clock_in) disable iff (!rst_n_in)
      first_pattern_trigger_out |-> exposure_trigger_out && pattern_index_out == PAT_RESET;
  endproperty
  a_first_only_exposed: assert property (p_first_only_exposed)
    else $error("first pattern flag without pattern zero");

  property p_advance_starts;
    @(posedge clock_in) disable iff (!rst_n_in)
      (advance_rise && state_q.seq != SEQ_EXPOSE && !state_q.paused) |=> exposure_trigger_out;
  endproperty
  a_advance_starts: assert property (p_advance_starts)
    else $error("advance did not start exposure");

  property p_pause_toggles;
    @(posedge clock_in) disable iff (!rst_n_in)
      (pause_rise && !advance_rise && !alternate_mode_in && state_q.seq != SEQ_EXPOSE)
      |=> paused_out != $past(paused_out);
  endproperty
  a_pause_toggles: assert property (p_pause_toggles)
    else $error("pause did not toggle");

  property p_disable_all;
    @(posedge clock_in) disable iff (!rst_n_in)
      all_disable_in |=> !red_light_enable && !green_light_enable && !blue_light_enable;
  endproperty
  a_disable_all: assert property (p_disable_all)
    else $error("enables active while disabled");

  property p_pulse_needs_enable;
    @(posedge clock_in) disable iff (!rst_n_in)
      red_current_pulse |-> $past(red_light_enable);
  endproperty
  a_pulse_needs_enable: assert property (p_pulse_needs_enable)
    else $error("pulse without enable");

  property p_fault_lamp;
    @(posedge clock_in) disable iff (!rst_n_in)
      system_fault_in |=> !fault_status_out;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp)
    else $error("fault lamp lit during fault");

  property p_blink_frozen;
    @(posedge clock_in) disable iff (!rst_n_in)
      system_fault_in |=> $stable(alive_blink_out);
  endproperty
  a_blink_frozen: assert property (p_blink_frozen)
    else $error("blink moved during fault");

  property p_unconfigured_quiet;
    @(posedge clock_in) disable iff (!rst_n_in)
      !state_q.configured |-> !red_light_enable && !blue_current_pulse;
  endproperty
  a_unconfigured_quiet: assert property (p_unconfigured_quiet)
    else $error("output active before config");
endmodule

// ===== shared/pattern_trigger_pkg.sv
// constants for the pattern trigger and illumination controller
// assumes one 50 MHz clock and synchronous active-low reset
package pattern_trigger_pkg;
  localparam int CLOCK_HZ = 50_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = CLOCK_HZ / 1000 * BLINK_HALF_MS;
  localparam int BLINK_W = 24;
  localparam int PAT_W = 8;
  localparam int DUTY_W = 8;
  localparam int EXPO_W = 16;
  localparam logic [PAT_W-1:0] PAT_RESET = 8'h00;
  localparam logic [2:0] ENABLE_RESET = 3'h0;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
  localparam int CH_RED = 0;
  localparam int CH_GREEN = 1;
  localparam int CH_BLUE = 2;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXPOSE = 2'b01,
    SEQ_GAP = 2'b10
  } seq_state_type;
endpackage

// ===== hdl/trigger_sync.sv
// two-flop synchroniser with rising edge detect for one trigger input
// assumes input may be asynchronous to clock_in
`timescale 1ns/1ps
module trigger_sync
  import pattern_trigger_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic rise_out
);
  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
    logic rise;
  } sync_state_type;
  sync_state_type state_q, state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
    state_d.prev = state_q.stable;
    // first flop feeds only the second one
    state_d.rise = state_q.stable & ~state_q.prev;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise_out = state_q.rise;

  property p_rise_from_edge;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state_q.stable && !state_q.prev) |=> rise_out;
  endproperty
  a_rise_from_edge: assert property (p_rise_from_edge)
    else $error("edge not reported");
endmodule

// ===== tb/trigger_host_model.sv
// far side: processor pacing triggers, camera counting exposures
// assumes the bench asks for a trigger by a one-cycle request
`timescale 1ns/1ps
module trigger_host_model (
  input wire logic clock_in,
  input wire logic adv_req_in,
  input wire logic pause_req_in,
  input wire logic exposure_in,
  output logic advance_trigger_out,
  output logic pause_trigger_out,
  output int exposure_count_out
);
  int adv_left = 0;
  int pause_left = 0;
  logic expo_last = 1'b0;
  initial begin
    advance_trigger_out = 1'b0;
    pause_trigger_out = 1'b0;
    exposure_count_out = 0;
  end
  // processor paces patterns
  // pulse held 4 clocks so the synchroniser cannot miss it
  always @(posedge clock_in) begin
    adv_left <= adv_req_in ? 4 : (adv_left > 0 ? adv_left - 1 : 0);
    pause_left <= pause_req_in ? 4 : (pause_left > 0 ? pause_left - 1 : 0);
    advance_trigger_out <= adv_req_in || adv_left > 1;
    pause_trigger_out <= pause_req_in || pause_left > 1;
  end
  always @(posedge clock_in) begin
    expo_last <= exposure_in;
    if (exposure_in === 1'b1 && expo_last === 1'b0) exposure_count_out <= exposure_count_out + 1;
  end
endmodule

// ===== tb/pattern_trigger_illumination_ctrl_tb_top.sv
// self-checking bench for the pattern trigger and illumination controller
// assumes the far-side model drives the trigger pins; one 50 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module pattern_trigger_illumination_ctrl_tb_top;
  logic clock_in = 1'b0, rst_n_in = 1'b0, adv_req = 1'b0, pause_req = 1'b0;
  logic advance_trigger_in, pause_trigger_in, alternate_mode_in = 1'b0;
  logic config_valid_in = 1'b0, all_disable_in = 1'b0, system_fault_in = 1'b0;
  logic [7:0] pattern_count_in = 8'h03, red_duty_in = 8'h00;
  logic [7:0] green_duty_in = 8'h00, blue_duty_in = 8'h00, pattern_index_out;
  logic [15:0] exposure_cycles_in = 16'h0005;
  logic [2:0] channel_enable_in = 3'h0;
  logic exposure_trigger_out, first_pattern_trigger_out, paused_out, alive_blink_out;
  logic red_light_enable, green_light_enable, blue_light_enable, fault_status_out;
  logic red_current_pulse, green_current_pulse, blue_current_pulse;
  int exposure_count, checked = 0, miscompares = 0, cycles = 0;
  typedef struct {logic [2:0] en; logic dis; logic [2:0] ex;} row_type;
  row_type rows[5] = '{'{3'h1, 1'b0, 3'h1}, '{3'h2, 1'b0, 3'h2}, '{3'h4, 1'b0, 3'h4},
                       '{3'h7, 1'b1, 3'h0}, '{3'h7, 1'b0, 3'h7}};
  always #10 clock_in = ~clock_in;
  trigger_host_model far_u (.clock_in(clock_in), .adv_req_in(adv_req),
    .pause_req_in(pause_req), .exposure_in(exposure_trigger_out),
    .advance_trigger_out(advance_trigger_in), .pause_trigger_out(pause_trigger_in),
    .exposure_count_out(exposure_count));
  pattern_trigger_illumination_ctrl dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .advance_trigger_in(advance_trigger_in), .pause_trigger_in(pause_trigger_in),
    .alternate_mode_in(alternate_mode_in), .pattern_count_in(pattern_count_in),
    .exposure_cycles_in(exposure_cycles_in), .config_valid_in(config_valid_in),
    .channel_enable_in(channel_enable_in), .all_disable_in(all_disable_in),
    .red_duty_in(red_duty_in), .green_duty_in(green_duty_in), .blue_duty_in(blue_duty_in),
    .system_fault_in(system_fault_in), .exposure_trigger_out(exposure_trigger_out),
    .first_pattern_trigger_out(first_pattern_trigger_out),
    .pattern_index_out(pattern_index_out), .paused_out(paused_out),
    .red_light_enable(red_light_enable), .green_light_enable(green_light_enable),
    .blue_light_enable(blue_light_enable), .red_current_pulse(red_current_pulse),
    .green_current_pulse(green_current_pulse), .blue_current_pulse(blue_current_pulse),
    .alive_blink_out(alive_blink_out), .fault_status_out(fault_status_out));
  task automatic tick(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic finish_test();
    $display("counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ceiling well above the several hundred cycles the tests need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic trig(input logic adv, output logic fp, output logic [7:0] ix, output int w);
    int k;
    @(posedge clock_in);
    if (adv) adv_req <= 1'b1;
    else pause_req <= 1'b1;
    @(posedge clock_in);
    adv_req <= 1'b0;
    pause_req <= 1'b0;
    k = 0;
    while (exposure_trigger_out !== 1'b1 && k < 30) begin tick(1); k++; end
    fp = first_pattern_trigger_out;
    ix = pattern_index_out;
    w = 0;
    while (exposure_trigger_out === 1'b1 && w < 100) begin w++; tick(1); end
    tick(10);
  endtask
  initial begin
    logic fp;
    logic [7:0] ix, iy;
    int w, n, hi[3];
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    channel_enable_in <= 3'h7;
    red_duty_in <= 8'hFF;
    tick(5);
    `CHK("enables", 3'h0, {blue_light_enable, green_light_enable, red_light_enable})
    `CHK("red pulse", 1'b0, red_current_pulse)
    $display("test reset done");
    @(posedge clock_in);
    config_valid_in <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clock_in);
      channel_enable_in <= rows[i].en;
      all_disable_in <= rows[i].dis;
      tick(3);
      `CHK("enables", rows[i].ex, {blue_light_enable, green_light_enable, red_light_enable})
    end
    $display("test enables done"); // rows cover single emitter and all-off
    @(posedge clock_in);
    red_duty_in <= 8'h40;
    blue_duty_in <= 8'hFF;
    tick(4);
    hi = '{0, 0, 0};
    repeat (256) begin
      tick(1);
      hi[0] += (red_current_pulse === 1'b1);
      hi[1] += (green_current_pulse === 1'b1);
      hi[2] += (blue_current_pulse === 1'b1);
    end
    `CHK("red duty", 64, hi[0])
    `CHK("green duty", 0, hi[1])
    `CHK("blue duty", 255, hi[2])
    $display("test pulses done");
    for (int i = 0; i < 4; i++) begin
      trig(1'b1, fp, ix, w);
      `CHK("index", i % 3, ix)
      `CHK("first", i % 3 == 0, fp)
      `CHK("width", 5, w)
    end
    @(posedge clock_in);
    exposure_cycles_in <= 16'h0000;
    trig(1'b1, fp, ix, w);
    `CHK("short width", 1, w)
    trig(1'b0, fp, ix, w);
    `CHK("paused", 1'b1, paused_out)
    n = exposure_count;
    iy = pattern_index_out;
    trig(1'b1, fp, ix, w);
    `CHK("no exposure", n, exposure_count)
    `CHK("held index", iy, pattern_index_out)
    trig(1'b0, fp, ix, w);
    `CHK("resumed", 1'b0, paused_out)
    $display("test sequence done");
    @(posedge clock_in);
    alternate_mode_in <= 1'b1;
    trig(1'b1, fp, ix, w);
    trig(1'b1, fp, iy, w);
    `CHK("alt toggle", {7'h00, ~ix[0]}, iy)
    trig(1'b0, fp, ix, w);
    `CHK("alt skip", (iy + 8'h02) % 8'h03, pattern_index_out)
    $display("test alternate done");
    @(posedge clock_in);
    system_fault_in <= 1'b1;
    tick(4);
    `CHK("fault lamp", 1'b0, fault_status_out)
    @(posedge clock_in);
    system_fault_in <= 1'b0;
    tick(4);
    `CHK("fault lamp", 1'b1, fault_status_out)
    // half blink period is far longer than this run
    `CHK("blink", 1'b0, alive_blink_out)
    $display("test fault done");
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    config_valid_in <= 1'b0;
    tick(3);
    `CHK("reset enables", 3'h0, {blue_light_enable, green_light_enable, red_light_enable})
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    tick(3);
    `CHK("lamp after reset", 1'b1, fault_status_out)
    `CHK("enables after reset", 3'h0, {blue_light_enable, green_light_enable, red_light_enable})
    `CHK("red pulse after reset", 1'b0, red_current_pulse)
    $display("test reset again done");
    finish_test();
  end
endmodule
